// ---- core/afr_top.v ----
// Purpose: 8-bit alu with condition flag register
// Assumes: one alu operation per valid cycle, wishbone register access
// Notes: flags update one edge after alu_valid_i
//
// Overview of operation
// - signed test flag equals overflow xor msb
// - plain subtract copies zero into chained null
// - borrow subtract ands chained null with zero
// - other operations leave chained null untouched
// - half flag is low nibble carry/no-borrow
// - timeout flag: power-up, kick, sleep clear; expiry sets
// - sleep flag: power-up, kick clear; sleep sets
// - carry is carry-out/no-borrow, rotates update it
// - overflow is carry into msb xor out
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "afr_defines.vh"
module afr_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire wb_ack_o,
  output reg [31:0] wb_dat_o,
  input wire alu_valid_i,
  input wire [3:0] alu_op_i,
  input wire [7:0] alu_a_i,
  input wire [7:0] alu_b_i,
  input wire guard_expire_i,
  input wire guard_kick_instr_i,
  input wire sleep_instr_i,
  output reg [7:0] alu_result_o,
  output reg alu_done_o,
  output wire [7:0] flags_o
);

////////////////////////////////////////////////////////////////////////////////
// state
reg signed_test_flag_r;
reg chained_null_flag_r;
reg signed_range_error_flag_r;
reg zero_flag_r;
reg nibble_half_flag_r;
reg carry_flag_r;
reg [3:0] last_op_r;

// unknown power-on bits start at zero so every run begins clean
localparam [7:0] FLAGS_RST = `AFR_FLAGS_RST;

reg signed_test_flag_nxt;
reg chained_null_flag_nxt;
reg signed_range_error_flag_nxt;
reg zero_flag_nxt;
reg nibble_half_flag_nxt;
reg carry_flag_nxt;

wire guard_timeout_flag;
wire sleep_entered_flag;
wire req;
wire flags_wr;
wire [1:0] rd_idx;

////////////////////////////////////////////////////////////////////////////////
// submodules
afr_wb_slave u_bus (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_ack_o(wb_ack_o),
  .req_o(req),
  .flags_wr_o(flags_wr),
  .rd_idx_o(rd_idx)
);

afr_sys_flags u_sys (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .guard_expire_i(guard_expire_i),
  .guard_kick_instr_i(guard_kick_instr_i),
  .sleep_instr_i(sleep_instr_i),
  .guard_timeout_flag_o(guard_timeout_flag),
  .sleep_entered_flag_o(sleep_entered_flag)
);

////////////////////////////////////////////////////////////////////////////////
// adder path shared by add and subtract forms
reg is_arith;
reg is_sub;
reg [7:0] b_eff;
reg cin;
reg [8:0] sum9;
reg [4:0] lo5;
reg [7:0] lo8;
reg [7:0] res;
reg res_c;
reg upd_c;
reg upd_ac_ov;
reg upd_z;
reg upd_any;

always @* begin
  is_arith = 1'b0;
  is_sub = 1'b0;
  cin = 1'b0;
  // adc and sbc chain on the carry held from the previous op
  case (alu_op_i)
    `AFR_OP_ADD: begin
      is_arith = 1'b1;
    end
    `AFR_OP_ADC: begin
      is_arith = 1'b1;
      cin = carry_flag_r;
    end
    `AFR_OP_SUB: begin
      is_arith = 1'b1;
      is_sub = 1'b1;
      cin = 1'b1;
    end
    `AFR_OP_SBC: begin
      is_arith = 1'b1;
      is_sub = 1'b1;
      cin = carry_flag_r;
    end
    default: begin
      is_arith = 1'b0;
    end
  endcase
  // subtract as a + ~b + cin so carry out means no borrow
  // lo8 bit 7 is the carry into the msb, used for overflow
  b_eff = is_sub ? ~alu_b_i : alu_b_i;
  sum9 = {1'b0, alu_a_i} + {1'b0, b_eff} + {8'h00, cin};
  lo5 = {1'b0, alu_a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  lo8 = {1'b0, alu_a_i[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
end

always @* begin
  res = alu_a_i;
  res_c = carry_flag_r;
  upd_c = 1'b0;
  upd_ac_ov = 1'b0;
  upd_z = 1'b0;
  if (is_arith) begin
    res = sum9[7:0];
    res_c = sum9[8];
    upd_c = 1'b1;
    upd_ac_ov = 1'b1;
    upd_z = 1'b1;
  end else begin
    case (alu_op_i)
      `AFR_OP_AND: begin
        res = alu_a_i & alu_b_i;
        upd_z = 1'b1;
      end
      `AFR_OP_OR: begin
        res = alu_a_i | alu_b_i;
        upd_z = 1'b1;
      end
      `AFR_OP_XOR: begin
        res = alu_a_i ^ alu_b_i;
        upd_z = 1'b1;
      end
      `AFR_OP_RRC: begin
        res = {carry_flag_r, alu_a_i[7:1]};
        res_c = alu_a_i[0];
        upd_c = 1'b1;
      end
      `AFR_OP_RLC: begin
        res = {alu_a_i[6:0], carry_flag_r};
        res_c = alu_a_i[7];
        upd_c = 1'b1;
      end
      `AFR_OP_INC: begin
        res = alu_a_i + 8'h01;
        upd_z = 1'b1;
      end
      `AFR_OP_DEC: begin
        res = alu_a_i - 8'h01;
        upd_z = 1'b1;
      end
      `AFR_OP_CPL: begin
        res = ~alu_a_i;
        upd_z = 1'b1;
      end
      default: begin
        res = alu_a_i;
      end
    endcase
  end
  upd_any = upd_c | upd_z;
end

////////////////////////////////////////////////////////////////////////////////
// next flag values: bus write first, alu result overrides it
always @* begin
  signed_test_flag_nxt = signed_test_flag_r;
  chained_null_flag_nxt = chained_null_flag_r;
  signed_range_error_flag_nxt = signed_range_error_flag_r;
  zero_flag_nxt = zero_flag_r;
  nibble_half_flag_nxt = nibble_half_flag_r;
  carry_flag_nxt = carry_flag_r;
  // time-out and sleep bits are not in the write path
  if (flags_wr) begin
    signed_test_flag_nxt = wb_dat_i[`AFR_SC_BIT];
    chained_null_flag_nxt = wb_dat_i[`AFR_CZ_BIT];
    signed_range_error_flag_nxt = wb_dat_i[`AFR_OV_BIT];
    zero_flag_nxt = wb_dat_i[`AFR_Z_BIT];
    nibble_half_flag_nxt = wb_dat_i[`AFR_AC_BIT];
    carry_flag_nxt = wb_dat_i[`AFR_C_BIT];
  end
  if (alu_valid_i) begin
    if (upd_c) begin
      carry_flag_nxt = res_c;
    end
    if (upd_ac_ov) begin
      nibble_half_flag_nxt = lo5[4];
      signed_range_error_flag_nxt = lo8[7] ^ sum9[8];
    end
    if (upd_z) begin
      zero_flag_nxt = (res == 8'h00);
    end
    if (upd_any) begin
      signed_test_flag_nxt = signed_range_error_flag_nxt ^ res[7];
    end
    // only the two subtract groups touch the chained flag
    case (alu_op_i)
      `AFR_OP_SUB: begin
        chained_null_flag_nxt = (res == 8'h00);
      end
      `AFR_OP_SBC: begin
        chained_null_flag_nxt = chained_null_flag_r & (res == 8'h00);
      end
      default: begin
        chained_null_flag_nxt = chained_null_flag_nxt;
      end
    endcase
  end
end

always @(posedge clk_i) begin
  if (rst_i) begin
    signed_test_flag_r <= FLAGS_RST[`AFR_SC_BIT];
    chained_null_flag_r <= FLAGS_RST[`AFR_CZ_BIT];
    signed_range_error_flag_r <= FLAGS_RST[`AFR_OV_BIT];
    zero_flag_r <= FLAGS_RST[`AFR_Z_BIT];
    nibble_half_flag_r <= FLAGS_RST[`AFR_AC_BIT];
    carry_flag_r <= FLAGS_RST[`AFR_C_BIT];
    alu_result_o <= `AFR_RESULT_RST;
    alu_done_o <= 1'b0;
    last_op_r <= 4'h0;
  end else begin
    signed_test_flag_r <= signed_test_flag_nxt;
    chained_null_flag_r <= chained_null_flag_nxt;
    signed_range_error_flag_r <= signed_range_error_flag_nxt;
    zero_flag_r <= zero_flag_nxt;
    nibble_half_flag_r <= nibble_half_flag_nxt;
    carry_flag_r <= carry_flag_nxt;
    alu_done_o <= alu_valid_i;
    if (alu_valid_i) begin
      alu_result_o <= res;
      last_op_r <= alu_op_i;
    end
  end
end

// system bits live in their own module, out of the write path
assign flags_o = {signed_test_flag_r, chained_null_flag_r, guard_timeout_flag,
                  sleep_entered_flag, signed_range_error_flag_r, zero_flag_r,
                  nibble_half_flag_r, carry_flag_r};

////////////////////////////////////////////////////////////////////////////////
// read data captured on the request edge, stands with ack
// limitation: a read shows the state one edge before ack
always @(posedge clk_i) begin
  if (rst_i) begin
    wb_dat_o <= 32'h00000000;
  end else if (req) begin
    case (rd_idx)
      2'h1: begin
        wb_dat_o <= {24'h000000, flags_o};
      end
      2'h2: begin
        wb_dat_o <= {24'h000000, alu_result_o};
      end
      2'h3: begin
        wb_dat_o <= {28'h0000000, last_op_r};
      end
      default: begin
        wb_dat_o <= 32'h00000000;
      end
    endcase
  end
end

endmodule

// ---- core/afr_defines.vh ----
// Purpose: constants for the alu flag register block
// Assumes: 8-bit alu, classic wishbone with 32-bit data
// Notes: offsets are byte addresses
`ifndef AFR_DEFINES_VH
`define AFR_DEFINES_VH

// flag bit positions
`define AFR_SC_BIT 3'd7
`define AFR_CZ_BIT 3'd6
`define AFR_TO_BIT 3'd5
`define AFR_PDF_BIT 3'd4
`define AFR_OV_BIT 3'd3
`define AFR_Z_BIT 3'd2
`define AFR_AC_BIT 3'd1
`define AFR_C_BIT 3'd0

// reset values and software write mask
`define AFR_FLAGS_RST 8'h00
`define AFR_RESULT_RST 8'h00
`define AFR_SW_MASK 8'hcf

// register byte offsets
`define AFR_OFS_FLAGS 4'h0
`define AFR_OFS_RESULT 4'h4
`define AFR_OFS_OPINFO 4'h8

// alu operation codes
`define AFR_OP_ADD 4'h0
`define AFR_OP_ADC 4'h1
`define AFR_OP_SUB 4'h2
`define AFR_OP_SBC 4'h3
`define AFR_OP_AND 4'h4
`define AFR_OP_OR 4'h5
`define AFR_OP_XOR 4'h6
`define AFR_OP_RRC 4'h7
`define AFR_OP_RLC 4'h8
`define AFR_OP_INC 4'h9
`define AFR_OP_DEC 4'ha
`define AFR_OP_CPL 4'hb
`define AFR_OP_MOV 4'hc

`endif

// ---- core/afr_sys_flags.v ----
// Purpose: time-out and power-down system flags
// Assumes: event inputs are one-cycle pulses
// Notes: no bus path reaches these flops
`timescale 1ns/1ps
module afr_sys_flags (
  input wire clk_i,
  input wire rst_i,
  input wire guard_expire_i,
  input wire guard_kick_instr_i,
  input wire sleep_instr_i,
  output reg guard_timeout_flag_o,
  output reg sleep_entered_flag_o
);

reg to_nxt;
reg pdf_nxt;

////////////////////////////////////////////////////////////////////////////////
always @* begin
  to_nxt = guard_timeout_flag_o;
  pdf_nxt = sleep_entered_flag_o;
  // set wins so an expiry beside a kick is not lost
  if (guard_expire_i) begin
    to_nxt = 1'b1;
  end else if (guard_kick_instr_i || sleep_instr_i) begin
    to_nxt = 1'b0;
  end
  if (sleep_instr_i) begin
    pdf_nxt = 1'b1;
  end else if (guard_kick_instr_i) begin
    pdf_nxt = 1'b0;
  end
end

always @(posedge clk_i) begin
  if (rst_i) begin
    guard_timeout_flag_o <= 1'b0;
    sleep_entered_flag_o <= 1'b0;
  end else begin
    guard_timeout_flag_o <= to_nxt;
    sleep_entered_flag_o <= pdf_nxt;
  end
end

endmodule

// ---- core/afr_wb_slave.v ----
// Purpose: classic wishbone handshake and address decode
// Assumes: master holds the request until it sees ack
// Notes: ack comes one cycle after the request, one cycle long
`timescale 1ns/1ps
`include "afr_defines.vh"
module afr_wb_slave (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  output reg wb_ack_o,
  output wire req_o,
  output wire flags_wr_o,
  output wire [1:0] rd_idx_o
);

function afr_hit;
  input [3:0] adr;
  input [3:0] ofs;
  begin
    afr_hit = (adr == ofs);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// request seen, answer not yet given
assign req_o = wb_cyc_i && wb_stb_i && !wb_ack_o;

// write lands on the edge where ack is sampled high
assign flags_wr_o = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                    afr_hit(wb_adr_i, `AFR_OFS_FLAGS);

assign rd_idx_o = afr_hit(wb_adr_i, `AFR_OFS_FLAGS) ? 2'h1 :
                  afr_hit(wb_adr_i, `AFR_OFS_RESULT) ? 2'h2 :
                  afr_hit(wb_adr_i, `AFR_OFS_OPINFO) ? 2'h3 : 2'h0;

always @(posedge clk_i) begin
  if (rst_i) begin
    wb_ack_o <= 1'b0;
  end else begin
    wb_ack_o <= req_o;
  end
end

endmodule

// ---- verif/afr_top_chk.sv ----
// Purpose: port checker for the flag register
// Assumes: no flag write lands in an alu cycle
// Notes: bound to afr_top below
`timescale 1ns/1ps
module afr_top_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire alu_valid_i,
  input wire [3:0] alu_op_i,
  input wire [7:0] alu_a_i,
  input wire [7:0] alu_b_i,
  input wire guard_expire_i,
  input wire guard_kick_instr_i,
  input wire sleep_instr_i,
  input wire [7:0] alu_result_o,
  input wire alu_done_o,
  input wire [7:0] flags_o
);
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_add;
    alu_done_o && $past(alu_op_i) == 4'h0;
  endsequence
  sequence s_upd;
    alu_done_o && $past(alu_op_i) < 4'h7;
  endsequence
  a_ack_pulse: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  a_sc_xor: assert property (s_upd |-> flags_o[7] == (flags_o[3] ^ alu_result_o[7]))
    else $error("signed test flag wrong");
  a_cz_sub: assert property (alu_done_o && $past(alu_op_i) == 4'h2 |->
    flags_o[6] == flags_o[2]) else $error("chained flag not zero copy");
  a_cz_chain: assert property (alu_done_o && $past(alu_op_i) == 4'h3 |->
    flags_o[6] == ($past(flags_o[6]) & flags_o[2])) else $error("chained flag not anded");
  a_cz_keep: assert property ($past(alu_valid_i) && $past(alu_op_i[3:1]) != 3'h1 &&
    !$past(wb_we_i && wb_stb_i) |-> $stable(flags_o[6])) else $error("chained flag moved");
  a_sys_hold: assert property (!$past(guard_expire_i || guard_kick_instr_i ||
    sleep_instr_i) |-> $stable(flags_o[5:4])) else $error("system flags moved");
  a_to_set: assert property ($past(guard_expire_i) |-> flags_o[5])
    else $error("timeout flag not set");
  a_pdf_set: assert property ($past(sleep_instr_i) |-> flags_o[4] &&
    flags_o[5] == $past(guard_expire_i)) else $error("sleep flags wrong");
  a_kick_clr: assert property ($past(guard_kick_instr_i && !sleep_instr_i &&
    !guard_expire_i) |-> flags_o[5:4] == 2'h0) else $error("kick did not clear");
  a_add_carry: assert property (s_add |-> {flags_o[0], alu_result_o} ==
    $past(alu_a_i) + $past(alu_b_i)) else $error("add carry wrong");
  a_add_half: assert property (s_add |-> flags_o[1] ==
    ($past(alu_a_i[3:0]) + $past(alu_b_i[3:0]) > 5'h0f)) else $error("half flag wrong");
  a_add_ovf: assert property (s_add |-> flags_o[3] ==
    ($past(alu_a_i[7]) == $past(alu_b_i[7]) && alu_result_o[7] != $past(alu_a_i[7])))
    else $error("overflow wrong");
  a_zero_res: assert property (s_upd |-> flags_o[2] == (alu_result_o == 8'h00))
    else $error("zero flag wrong");
  c_chain: cover property (alu_done_o && flags_o[6]);
  c_wr: cover property (wb_ack_o && wb_we_i);
  c_sys: cover property (flags_o[5:4] == 2'h3);
endmodule
bind afr_top afr_top_chk afr_top_chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .alu_valid_i(alu_valid_i),
  .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .guard_expire_i(guard_expire_i),
  .guard_kick_instr_i(guard_kick_instr_i), .sleep_instr_i(sleep_instr_i),
  .alu_result_o(alu_result_o), .alu_done_o(alu_done_o), .flags_o(flags_o));

// ---- verif/afr_top_tb.sv ----
// Purpose: directed bench for the flag register
// Assumes: ack one cycle after request
// Notes: flag reset bits are zero by choice
`timescale 1ns/1ps
module afr_top_tb;
  reg clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg alu_valid_i = 1'b0, guard_expire_i = 1'b0, guard_kick_instr_i = 1'b0, sleep_instr_i = 1'b0;
  reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, alu_op_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0, rd;
  reg [7:0] alu_a_i = 8'h00, alu_b_i = 8'h00;
  reg [55:0] tbl [0:11];
  reg [55:0] e;
  wire wb_ack_o, alu_done_o;
  wire [31:0] wb_dat_o;
  wire [7:0] alu_result_o, flags_o;
  integer mismatches = 0, n_checks = 0, cyc_n = 0, i;
  afr_top afr_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .alu_valid_i(alu_valid_i), .alu_op_i(alu_op_i),
    .alu_a_i(alu_a_i), .alu_b_i(alu_b_i), .guard_expire_i(guard_expire_i),
    .guard_kick_instr_i(guard_kick_instr_i), .sleep_instr_i(sleep_instr_i),
    .alu_result_o(alu_result_o), .alu_done_o(alu_done_o), .flags_o(flags_o));
  ////////////////////////////////////////
  always #4 clk_i = ~clk_i;
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // hang guard, tests need well under this
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 3000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wb(input w, input [3:0] a, input [3:0] s, input [7:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
        @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask
  task fchk(input [7:0] exp);
    begin
      @(posedge clk_i);
      #1;
      check(flags_o, exp);
    end
  endtask
  task sys(input x, input k, input s, input [7:0] exp);
    begin
      @(posedge clk_i);
      guard_expire_i <= x;
      guard_kick_instr_i <= k;
      sleep_instr_i <= s;
      @(posedge clk_i);
      guard_expire_i <= 1'b0;
      guard_kick_instr_i <= 1'b0;
      sleep_instr_i <= 1'b0;
      fchk(exp);
    end
  endtask
  task alu_go(input [3:0] op, input [7:0] a, input [7:0] b);
    begin
      @(posedge clk_i);
      alu_valid_i <= 1'b1;
      alu_op_i <= op;
      alu_a_i <= a;
      alu_b_i <= b;
    end
  endtask
  task alu_end(input [7:0] res, input [7:0] fl, input [7:0] m);
    begin
      @(posedge clk_i);
      alu_valid_i <= 1'b0;
      #1;
      check(alu_done_o, 1'b1);
      check(alu_result_o, res);
      check(flags_o & m, fl);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    // pre, op, a, b, result, flags, mask
    tbl[0] = 56'h00_00_7f_01_80_0a_ff;
    tbl[1] = 56'h40_00_ff_01_00_47_ff;
    tbl[2] = 56'h00_02_05_05_00_47_ff;
    tbl[3] = 56'h40_02_00_01_ff_80_ff;
    tbl[4] = 56'h41_03_10_10_00_47_ff;
    tbl[5] = 56'h01_03_10_10_00_07_ff;
    tbl[6] = 56'h40_03_10_0f_00_45_ff;
    tbl[7] = 56'h01_01_7f_00_80_0a_ff;
    tbl[8] = 56'h08_04_f0_0f_00_8c_ff;
    tbl[9] = 56'h00_06_80_01_81_80_ff;
    tbl[10] = 56'h01_07_02_02_81_80_ff;
    tbl[11] = 56'h00_08_81_81_02_01_ff;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    fchk(8'h00);
    wb(1'b1, 4'h0, 4'h1, 8'hff);
    fchk(8'hcf);
    wb(1'b1, 4'h0, 4'h0, 8'h00);
    wb(1'b0, 4'h0, 4'hf, 8'h00);
    check(rd, 32'hcf);
    wb(1'b1, 4'hc, 4'h1, 8'h00);
    wb(1'b0, 4'hc, 4'hf, 8'h00);
    check(rd, 32'h0);
    fchk(8'hcf);
    $display("bus test done");
    sys(1'b1, 1'b0, 1'b0, 8'hef);
    wb(1'b1, 4'h0, 4'h1, 8'h00);
    fchk(8'h20);
    sys(1'b0, 1'b1, 1'b0, 8'h00);
    sys(1'b0, 1'b0, 1'b1, 8'h10);
    wb(1'b1, 4'h0, 4'h1, 8'hff);
    fchk(8'hdf);
    sys(1'b1, 1'b0, 1'b0, 8'hff);
    sys(1'b0, 1'b0, 1'b1, 8'hdf);
    sys(1'b0, 1'b1, 1'b0, 8'hcf);
    sys(1'b1, 1'b1, 1'b0, 8'hef);
    sys(1'b0, 1'b1, 1'b1, 8'hdf);
    sys(1'b0, 1'b1, 1'b0, 8'hcf);
    $display("system flag test done");
    for (i = 0; i < 12; i = i + 1) begin
      e = tbl[i];
      wb(1'b1, 4'h0, 4'h1, e[55:48]);
      alu_go(e[43:40], e[39:32], e[31:24]);
      alu_end(e[23:16], e[15:8], e[7:0]);
    end
    $display("alu table test done");
    // back to back, chain set then broken
    wb(1'b1, 4'h0, 4'h1, 8'h00);
    alu_go(4'h2, 8'h05, 8'h05);
    alu_go(4'h3, 8'h00, 8'h00);
    alu_go(4'h3, 8'h01, 8'h00);
    alu_end(8'h01, 8'h03, 8'hff);
    $display("chain test done");
    wb(1'b0, 4'h4, 4'hf, 8'h00);
    check(rd, 32'h01);
    wb(1'b0, 4'h8, 4'hf, 8'h00);
    check(rd, 32'h3);
    wb(1'b1, 4'h4, 4'h1, 8'hff);
    wb(1'b0, 4'h4, 4'hf, 8'h00);
    check(rd, 32'h01);
    $display("readback test done");
    sys(1'b1, 1'b0, 1'b1, 8'h33);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    fchk(8'h00);
    check(alu_result_o, 32'h0);
    $display("reset test done");
    finish_test;
  end
endmodule
